// *** rtl/dcc_consts.vh ***
// Constants for the dual comparator control block.
// Assumes inclusion by the design files under rtl/.
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define DCC_IDX_CMP_CTRL 8'h1f
`define DCC_IDX_PORT_DIR 8'h85
`define DCC_IDX_FLAG_REG 8'h0c
`define DCC_IDX_ENAB_REG 8'h8c
`define DCC_IDX_IRQ_CTRL 8'h0b
`define DCC_IDX_PORT_DATA 8'h05
`define DCC_ADDR_CMP_CTRL 10'h07c
`define DCC_ADDR_PORT_DIR 10'h214
`define DCC_ADDR_FLAG_REG 10'h030
`define DCC_ADDR_ENAB_REG 10'h230
`define DCC_ADDR_IRQ_CTRL 10'h02c
`define DCC_ADDR_PORT_DATA 10'h014

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCC_BIT_CMP2 7
`define DCC_BIT_CMP1 6
`define DCC_BIT_SWITCH 3
`define DCC_BIT_FLAG 6
`define DCC_BIT_GIE 7
`define DCC_BIT_PERIPH_IRQ_EN 6

// ----------------------------------------
// Reset values and modes
// ----------------------------------------
`define DCC_RST_MODE 3'h0
`define DCC_RST_DIR 5'h1f
`define DCC_MODE_RESET 3'h0
`define DCC_MODE_ONE_MUX 3'h1
`define DCC_MODE_REF_MUX 3'h2
`define DCC_MODE_PIN_OUT 3'h6
`define DCC_MODE_OFF 3'h7

`endif

// *** rtl/dcc_sync2.v ***
// Two-flop synchroniser for the comparator results.
// Assumes asynchronous analog levels on din.
`timescale 1ns/1ps
module dcc_sync2 #(
    parameter WIDTH = 2
) (
    input wire ref_clk,
    input wire reset_n,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] stage1;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule // dcc_sync2

// *** rtl/dcc_route.v ***
// Analog input switch routing for both comparators.
// Assumes the analog muxes follow these select codes.
`timescale 1ns/1ps
`include "dcc_consts.vh"
module dcc_route (
    input wire [2:0] mode,
    input wire sw,
    output reg [2:0] c1_neg_sel,
    output reg [2:0] c2_neg_sel,
    output reg ref_to_pos,
    output reg [3:0] analog_mask,
    output reg cmp_on
);
    // ----------------------------------------
    // Select codes: pin number, 3'h7 none
    // ----------------------------------------
    always @* begin
        c1_neg_sel = 3'h0;
        c2_neg_sel = 3'h1;
        ref_to_pos = 1'b0;
        analog_mask = 4'hf;
        cmp_on = 1'b1;
        case (mode)
            `DCC_MODE_RESET: begin
                cmp_on = 1'b0;
            end
            // RQ5 single switch
            `DCC_MODE_ONE_MUX: begin
                c1_neg_sel = sw ? 3'h3 : 3'h0;
            end
            // RQ6 paired switch
            `DCC_MODE_REF_MUX: begin
                c1_neg_sel = sw ? 3'h3 : 3'h0;
                c2_neg_sel = sw ? 3'h2 : 3'h1;
                // RQ7 reference to plus
                ref_to_pos = 1'b1;
            end
            3'h3: begin
                analog_mask = 4'h7;
            end
            `DCC_MODE_PIN_OUT: begin
                analog_mask = 4'h7;
            end
            // RQ21 both comparators off
            `DCC_MODE_OFF: begin
                analog_mask = 4'h0;
                cmp_on = 1'b0;
                c1_neg_sel = 3'h7;
                c2_neg_sel = 3'h7;
            end
            default: begin
                analog_mask = 4'hf;
            end
        endcase
    end
endmodule // dcc_route

// *** rtl/dcc_top.v ***
// Control and status logic around two analog comparators.
// Assumes an AHB-Lite master and asynchronous comparator levels.
`timescale 1ns/1ps
`include "dcc_consts.vh"

// Contract
// RQ1: Results readable in control bits 7 and 6, comparator 2 on top.
// RQ2: Result bit is one when plus input exceeds minus input.
// RQ3: Control bits 5 and 4 always read zero.
// RQ4: Three-bit mode field in bits 2-0 picks one of eight modes.
// RQ5: Mode 001: switch picks pin 3 or pin 0 for comparator 1 minus.
// RQ6: Mode 010: switch picks pins 3 and 2, else 0 and 1.
// RQ7: Mode 010 drives internal reference onto both plus inputs.
// RQ8: Mode 110 puts raw comparator results onto pins 3 and 4.
// RQ9: Direction bits still gate the outputs of pins 3 and 4.
// RQ10: Port data reads zero on every analog-configured pin.
// RQ11: Software should mask the interrupt while changing mode.
// RQ12: Change flag sets whenever either result changes.
// RQ13: Writing zero clears the flag, writing one sets it.
// RQ14: Request needs all three enables; flag sets regardless.
// RQ15: A change during a control access may be missed.
// RQ16: Any control access ends the pending mismatch.
// RQ17: Ongoing mismatch keeps setting the flag.
// RQ18: Snapshot of results at access compared each cycle.
// RQ19: Results synchronised twice, pins use raw results.
// RQ20: Reset selects mode 000, comparators powered down.
// RQ21: Mode 111 switches both comparators off.
module dcc_top (
    input wire ref_clk,
    input wire reset_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire cmp1_result,
    input wire cmp2_result,
    input wire [4:0] port_pin_in,
    output reg [4:0] port_pin_out,
    output reg [4:0] port_pin_oe,
    output reg [2:0] cmp1_neg_sel,
    output reg [2:0] cmp2_neg_sel,
    output reg ref_to_pos,
    output reg cmp_power_on,
    output reg cmp_irq
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [2:0] cmp_mode_sel;
    reg input_switch_sel;
    reg [4:0] port_a_direction;
    reg [4:0] port_latch;
    reg cmp_change_flag;
    reg cmp_change_irq_en;
    reg periph_irq_en;
    reg global_irq_en;
    reg [1:0] seen;
    reg ph_valid;
    reg ph_write;
    reg [9:0] ph_addr;
    wire [1:0] sync_res;
    wire [2:0] r_c1;
    wire [2:0] r_c2;
    wire r_ref;
    wire [3:0] r_mask;
    wire r_on;
    wire ap_take;
    wire ctrl_acc;
    wire mismatch;
    wire [7:0] wbyte;
    reg [7:0] next_rdata;
    reg [4:0] next_pin_out;

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    // RQ19 two stage sync
    dcc_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .din({cmp2_result, cmp1_result}),
        .dout(sync_res)
    );

    dcc_route u_route (
        .mode(cmp_mode_sel),
        .sw(input_switch_sel),
        .c1_neg_sel(r_c1),
        .c2_neg_sel(r_c2),
        .ref_to_pos(r_ref),
        .analog_mask(r_mask),
        .cmp_on(r_on)
    );

    function addr_is;
        input [9:0] a;
        input [9:0] b;
        begin
            addr_is = (a == b);
        end
    endfunction

    // ----------------------------------------
    // Bus phases
    // ----------------------------------------
    assign ap_take = hsel & hready & htrans[1];
    assign wbyte = hwdata[7:0];
    // RQ16 access ends mismatch
    assign ctrl_acc = ph_valid & addr_is(ph_addr, `DCC_ADDR_CMP_CTRL);
    // RQ18 snapshot compare
    assign mismatch = (seen != sync_res);

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 10'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ph_valid <= ap_take;
            ph_write <= hwrite;
            ph_addr <= haddr[9:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always @* begin
        next_rdata = 8'h00;
        // RQ1 result bits
        if (addr_is(haddr[9:0], `DCC_ADDR_CMP_CTRL)) begin
            // RQ3 bits read zero
            next_rdata = {sync_res[1], sync_res[0], 2'b00, input_switch_sel,
                cmp_mode_sel};
        end else if (addr_is(haddr[9:0], `DCC_ADDR_PORT_DIR)) begin
            next_rdata = {3'b000, port_a_direction};
        end else if (addr_is(haddr[9:0], `DCC_ADDR_FLAG_REG)) begin
            next_rdata = {1'b0, cmp_change_flag, 6'h00};
        end else if (addr_is(haddr[9:0], `DCC_ADDR_ENAB_REG)) begin
            next_rdata = {1'b0, cmp_change_irq_en, 6'h00};
        end else if (addr_is(haddr[9:0], `DCC_ADDR_IRQ_CTRL)) begin
            next_rdata = {global_irq_en, periph_irq_en, 6'h00};
        end else if (addr_is(haddr[9:0], `DCC_ADDR_PORT_DATA)) begin
            // RQ10 analog pins read zero
            next_rdata = {3'b000, port_pin_in[4], port_pin_in[3:0] & ~r_mask};
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
        end else if (ap_take && !hwrite) begin
            hrdata <= {24'h000000, next_rdata};
        end
    end

    // ----------------------------------------
    // Control writes
    // ----------------------------------------
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            // RQ20 reset mode
            cmp_mode_sel <= `DCC_RST_MODE;
            input_switch_sel <= 1'b0;
            port_a_direction <= `DCC_RST_DIR;
            port_latch <= 5'h00;
            cmp_change_irq_en <= 1'b0;
            periph_irq_en <= 1'b0;
            global_irq_en <= 1'b0;
        end else if (ph_valid && ph_write) begin
            // RQ4 mode field
            if (addr_is(ph_addr, `DCC_ADDR_CMP_CTRL)) begin
                cmp_mode_sel <= wbyte[2:0];
                input_switch_sel <= wbyte[`DCC_BIT_SWITCH];
            end
            if (addr_is(ph_addr, `DCC_ADDR_PORT_DIR)) begin
                port_a_direction <= wbyte[4:0];
            end
            if (addr_is(ph_addr, `DCC_ADDR_PORT_DATA)) begin
                port_latch <= wbyte[4:0];
            end
            if (addr_is(ph_addr, `DCC_ADDR_ENAB_REG)) begin
                cmp_change_irq_en <= wbyte[`DCC_BIT_FLAG];
            end
            if (addr_is(ph_addr, `DCC_ADDR_IRQ_CTRL)) begin
                global_irq_en <= wbyte[`DCC_BIT_GIE];
                periph_irq_en <= wbyte[`DCC_BIT_PERIPH_IRQ_EN];
            end
        end
    end

    // ----------------------------------------
    // Change detection
    // ----------------------------------------
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            seen <= 2'b00;
        end else if (ctrl_acc) begin
            // RQ15 access reloads copy
            seen <= sync_res;
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_change_flag <= 1'b0;
        end else if (mismatch && !ctrl_acc) begin
            // RQ12 RQ17 mismatch sets flag
            cmp_change_flag <= 1'b1;
        end else if (ph_valid && ph_write && addr_is(ph_addr, `DCC_ADDR_FLAG_REG)) begin
            // RQ13 software write
            cmp_change_flag <= wbyte[`DCC_BIT_FLAG];
        end
    end

    // ----------------------------------------
    // Pins and outputs
    // ----------------------------------------
    always @* begin
        next_pin_out = port_latch;
        // RQ8 raw results on pins
        if (cmp_mode_sel == `DCC_MODE_PIN_OUT) begin
            next_pin_out[3] = cmp1_result;
            next_pin_out[4] = cmp2_result;
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_pin_out <= 5'h00;
            port_pin_oe <= 5'h00;
            cmp1_neg_sel <= 3'h0;
            cmp2_neg_sel <= 3'h1;
            ref_to_pos <= 1'b0;
            cmp_power_on <= 1'b0;
            cmp_irq <= 1'b0;
        end else begin
            port_pin_out <= next_pin_out;
            // RQ9 direction gates outputs
            port_pin_oe <= ~port_a_direction & {1'b1, ~r_mask};
            cmp1_neg_sel <= r_c1;
            cmp2_neg_sel <= r_c2;
            ref_to_pos <= r_ref;
            cmp_power_on <= r_on;
            // RQ14 three enables
            cmp_irq <= cmp_change_flag & cmp_change_irq_en & periph_irq_en & global_irq_en;
        end
    end
endmodule // dcc_top

// *** test/dcc_analog_model.sv ***
// Analog side model: pin levels and comparators.
// Assumes the bench sets the plus and minus levels.
`timescale 1ns/1ps
module dcc_analog_model (
    input wire cmp_power_on,
    input wire [3:0] vp1,
    input wire [3:0] vn1,
    input wire [3:0] vp2,
    input wire [3:0] vn2,
    output wire cmp1_result,
    output wire cmp2_result
);
    assign cmp1_result = cmp_power_on && (vp1 > vn1);
    assign cmp2_result = cmp_power_on && (vp2 > vn2);
endmodule // dcc_analog_model

// *** test/dcc_top_sva.sv ***
// Checker on the comparator control ports.
// Assumes bind to dcc_top and its byte map.
`timescale 1ns/1ps
`include "dcc_consts.vh"
module dcc_top_sva (
    input wire ref_clk,
    input wire reset_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire cmp1_result,
    input wire cmp2_result,
    input wire [4:0] port_pin_out,
    input wire [4:0] port_pin_oe,
    input wire [2:0] cmp1_neg_sel,
    input wire [2:0] cmp2_neg_sel,
    input wire ref_to_pos,
    input wire cmp_power_on
);
    // ----
    // Bus shadow
    // ----
    reg dp;
    reg dpw;
    reg sw;
    reg [9:0] dpa;
    reg [2:0] mode;
    reg [2:0] cnt;
    reg [4:0] dir;
    wire st = cnt > 3'h3;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dp <= 1'b0;
            dpw <= 1'b0;
            dpa <= 10'h000;
            mode <= 3'h0;
            sw <= 1'b0;
            dir <= 5'h1f;
            cnt <= 3'h0;
        end else begin
            dp <= hsel && hready && htrans[1];
            dpw <= hwrite;
            dpa <= haddr[9:0];
            if (cnt != 3'h7)
                cnt <= cnt + 3'h1;
            if (dp && dpw && dpa == `DCC_ADDR_CMP_CTRL) begin
                mode <= hwdata[2:0];
                sw <= hwdata[3];
                cnt <= 3'h0;
            end
            if (dp && dpw && dpa == `DCC_ADDR_PORT_DIR) begin
                dir <= hwdata[4:0];
                cnt <= 3'h0;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_rd(a);
        dp && !dpw && dpa == a;
    endsequence
    sequence s_in(m);
        st && mode == m;
    endsequence
    // ----
    // Assertions
    // ----
    a_ref_mode: assert property (st |-> ref_to_pos == (mode == 3'h2))
        else $error("reference routing wrong");
    a_sel_one: assert property (s_in(3'h1) |-> cmp1_neg_sel == (sw ? 3'h3 : 3'h0))
        else $error("mode one switch wrong");
    a_sel_two: assert property (s_in(3'h2) |->
        cmp1_neg_sel == (sw ? 3'h3 : 3'h0) && cmp2_neg_sel == (sw ? 3'h2 : 3'h1))
        else $error("mode two switch wrong");
    a_power_off: assert property (st && (mode == 3'h0 || mode == 3'h7) |-> !cmp_power_on)
        else $error("comparators not off");
    a_pin_raw: assert property (s_in(3'h6) |->
        port_pin_out[4:3] == {$past(cmp2_result), $past(cmp1_result)})
        else $error("pin result routing wrong");
    a_pin_oe: assert property (s_in(3'h6) |-> port_pin_oe[4:3] == ~dir[4:3])
        else $error("pin enable wrong");
    a_port_read: assert property (s_rd(`DCC_ADDR_PORT_DATA) ##0 st && mode != 3'h7
        |-> hrdata[2:0] == 3'h0)
        else $error("analog pin read not zero");
    a_ctrl_zero: assert property (s_rd(`DCC_ADDR_CMP_CTRL) |->
        hrdata[5:4] == 2'h0 && hrdata[31:8] == 24'h0)
        else $error("unused control bits set");
endmodule // dcc_top_sva
bind dcc_top dcc_top_sva u_dcc_top_sva (.ref_clk, .reset_n, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .cmp1_result, .cmp2_result, .port_pin_out,
    .port_pin_oe, .cmp1_neg_sel, .cmp2_neg_sel, .ref_to_pos, .cmp_power_on);

// *** test/dcc_top_test.sv ***
// Testbench for the comparator control block.
// Assumes one AHB-Lite slave and the analog model.
`timescale 1ns/1ps
`include "dcc_consts.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module dcc_top_test;
    logic ref_clk = 0;
    logic reset_n = 0;
    logic hsel = 0;
    logic [31:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic hwrite = 0;
    logic [31:0] hwdata = 0;
    logic [3:0] vp1 = 4'h9;
    logic [3:0] vn1 = 4'h3;
    logic [3:0] vp2 = 4'h2;
    logic [3:0] vn2 = 4'h8;
    wire hready;
    wire [31:0] hrdata;
    wire cmp1_result;
    wire cmp2_result;
    wire [4:0] port_pin_out;
    wire [4:0] port_pin_oe;
    wire [2:0] cmp1_neg_sel;
    wire [2:0] cmp2_neg_sel;
    wire ref_to_pos;
    wire cmp_power_on;
    wire cmp_irq;
    wire hresp;
    logic [7:0] q;
    logic [11:0] r;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    // Rows: switch, mode, reference, power, minus selects
    logic [11:0] rows [10] = '{12'h000, 12'h140, 12'h958, 12'h2c1, 12'hada,
        12'h340, 12'h440, 12'h540, 12'h640, 12'h700};
    dcc_top u_dcc_top (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .cmp1_result(cmp1_result),
        .cmp2_result(cmp2_result), .port_pin_in(5'h1f), .port_pin_out(port_pin_out),
        .port_pin_oe(port_pin_oe), .cmp1_neg_sel(cmp1_neg_sel),
        .cmp2_neg_sel(cmp2_neg_sel), .ref_to_pos(ref_to_pos),
        .cmp_power_on(cmp_power_on), .cmp_irq(cmp_irq));
    dcc_analog_model u_dcc_analog_model (.cmp_power_on(cmp_power_on), .vp1(vp1),
        .vn1(vn1), .vp2(vp2), .vn2(vn2), .cmp1_result(cmp1_result),
        .cmp2_result(cmp2_result));
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            stop_test;
        end
    end
    task stop_test;
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----
    // Single AHB-Lite transfer
    // ----
    task xfer(input [9:0] a, input w, input [7:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge ref_clk); while (hready !== 1'b1);
        q = hrdata[7:0];
    endtask
    function automatic [3:0] amask(input [2:0] m);
        amask = (m == 3'h7) ? 4'h0 : (m == 3'h3 || m == 3'h6) ? 4'h7 : 4'hf;
    endfunction
    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        xfer(`DCC_ADDR_CMP_CTRL, 0, 8'h00);
        `CHK(q, 8'h00)
        xfer(`DCC_ADDR_PORT_DIR, 0, 8'h00);
        `CHK(q, 8'h1f)
        xfer(10'h3fc, 0, 8'h00);
        `CHK(q, 8'h00)
        for (int i = 0; i < 10; i++) begin
            r = rows[i];
            xfer(`DCC_ADDR_CMP_CTRL, 1, {4'h0, r[11:8]});
            repeat (6) @(posedge ref_clk);
            `CHK({ref_to_pos, cmp_power_on}, r[7:6])
            if (r[10:8] == 3'h1 || r[10:8] == 3'h2)
                `CHK(cmp1_neg_sel, r[5:3])
            if (r[10:8] == 3'h2)
                `CHK(cmp2_neg_sel, r[2:0])
            xfer(`DCC_ADDR_CMP_CTRL, 0, 8'h00);
            `CHK(q, {1'b0, r[6], 2'h0, r[11:8]})
            xfer(`DCC_ADDR_PORT_DATA, 0, 8'h00);
            `CHK(q[4:0], {1'b1, ~amask(r[10:8])})
        end
        xfer(`DCC_ADDR_ENAB_REG, 1, 8'h40);
        xfer(`DCC_ADDR_IRQ_CTRL, 1, 8'h00);
        xfer(`DCC_ADDR_CMP_CTRL, 1, 8'h02);
        repeat (6) @(posedge ref_clk);
        xfer(`DCC_ADDR_CMP_CTRL, 0, 8'h00);
        xfer(`DCC_ADDR_FLAG_REG, 1, 8'h00);
        xfer(`DCC_ADDR_FLAG_REG, 0, 8'h00);
        `CHK(q, 8'h00)
        xfer(`DCC_ADDR_IRQ_CTRL, 1, 8'hc0);
        vp1 <= 4'h1;
        repeat (6) @(posedge ref_clk);
        xfer(`DCC_ADDR_FLAG_REG, 0, 8'h00);
        `CHK(q, 8'h40)
        `CHK(cmp_irq, 1'b1)
        xfer(`DCC_ADDR_FLAG_REG, 1, 8'h00);
        xfer(`DCC_ADDR_FLAG_REG, 0, 8'h00);
        `CHK(q, 8'h40)
        xfer(`DCC_ADDR_CMP_CTRL, 1, 8'h02);
        xfer(`DCC_ADDR_FLAG_REG, 1, 8'h00);
        xfer(`DCC_ADDR_FLAG_REG, 0, 8'h00);
        `CHK(q, 8'h00)
        xfer(`DCC_ADDR_FLAG_REG, 1, 8'h40);
        xfer(`DCC_ADDR_FLAG_REG, 0, 8'h00);
        `CHK(q, 8'h40)
        xfer(`DCC_ADDR_IRQ_CTRL, 1, 8'h40);
        repeat (2) @(posedge ref_clk);
        `CHK(cmp_irq, 1'b0)
        xfer(`DCC_ADDR_PORT_DIR, 1, 8'h07);
        xfer(`DCC_ADDR_CMP_CTRL, 1, 8'h06);
        vp1 <= 4'h9;
        repeat (4) @(posedge ref_clk);
        `CHK(port_pin_out[4:3], 2'h1)
        `CHK(port_pin_oe[4:3], 2'h3)
        xfer(`DCC_ADDR_PORT_DIR, 1, 8'h1f);
        repeat (3) @(posedge ref_clk);
        `CHK(port_pin_oe[4:3], 2'h0)
        // Mid-run reset
        xfer(`DCC_ADDR_PORT_DIR, 1, 8'h00);
        reset_n <= 1'b0;
        @(posedge ref_clk);
        `CHK({hresp, cmp_power_on, port_pin_oe}, 7'h00)
        reset_n <= 1'b1;
        xfer(`DCC_ADDR_CMP_CTRL, 0, 8'h00);
        `CHK(q, 8'h00)
        xfer(`DCC_ADDR_PORT_DIR, 0, 8'h00);
        `CHK(q, 8'h1f)
        stop_test;
    end
endmodule // dcc_top_test
